// >>> hdl/adcs_sequencer.sv
// successive-approximation converter sequencer with axi4-lite registers
//
// Our own choices: the AXI4-Lite register port and the address map.
module adcs_sequencer
  import adcs_pkg::*;
(
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write
  input  wire logic [7:0]        awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // axi4-lite read
  input  wire logic [7:0]        araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // analog front end
  input  wire logic              comp_in,
  output logic                   sample_en,
  output logic                   discharge,
  output logic [3:0]             channel_out,
  output logic [1:0]             ref_sel,
  output logic [9:0]             dac_code,
  // port pins and strap
  input  wire logic [NUM_CH-1:0] pin_in,
  input  wire logic              portb_analog_reset_cfg,
  // compare module
  input  wire logic [3:0]        compare_mode_sel,
  input  wire logic              compare_trig,
  output logic                   timer_clear
);
  // register state
  adcs_ctrl_s        ctrl_reg;
  adcs_pincfg_s      pcfg_reg;
  adcs_timing_s      tim_reg;
  logic [7:0]        res_hi_reg, res_lo_reg;
  logic              done_reg;
  adcs_state_e       state_reg, state_next;
  logic [7:0]        tad_cnt_reg;
  logic [4:0]        ph_cnt_reg;
  logic [9:0]        dac_reg;
  logic [1:0]        comp_ff_reg, strap_ff_reg, load_cnt_reg;
  logic [NUM_CH-1:0] pin_ff1_reg, pin_ff2_reg;
  logic [7:0]        awaddr_reg;
  logic [31:0]       wdata_reg;
  logic              wstrb0_reg;
  logic              awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0]        bresp_reg, rresp_reg;
  logic [31:0]       rdata_reg;
  logic              sample_reg, disch_reg, timer_clear_reg;

  // pin and comparator synchronisers
  always_ff @(posedge aclk) begin
    comp_ff_reg  <= {comp_ff_reg[0], comp_in};
    strap_ff_reg <= {strap_ff_reg[0], portb_analog_reset_cfg};
    pin_ff1_reg  <= pin_in;
    pin_ff2_reg  <= pin_ff1_reg;
  end

  // write decode
  wire do_write  = !awready_reg && !wready_reg && !bvalid_reg;
  wire wr_en     = do_write && wstrb0_reg;
  wire wr_hit    = (awaddr_reg == OFF_RES_HI) || (awaddr_reg == OFF_RES_LO) ||
                   (awaddr_reg == OFF_CTRL) || (awaddr_reg == OFF_PINCFG) ||
                   (awaddr_reg == OFF_TIMING) || (awaddr_reg == OFF_STATUS) ||
                   (awaddr_reg == OFF_PORT);
  wire wr_res_hi = wr_en && (awaddr_reg == OFF_RES_HI);
  wire wr_res_lo = wr_en && (awaddr_reg == OFF_RES_LO);
  wire wr_ctrl   = wr_en && (awaddr_reg == OFF_CTRL);
  wire wr_pcfg   = wr_en && (awaddr_reg == OFF_PINCFG);
  wire wr_tim    = wr_en && (awaddr_reg == OFF_TIMING);
  wire wr_stat   = wr_en && (awaddr_reg == OFF_STATUS);

  // bit period timing
  wire        tad_tick = (tad_cnt_reg == 8'h00);
  wire [7:0]  tad_len  = tad_div(tim_reg.conv_clock_sel);
  wire [4:0]  acq_len  = acq_tads(tim_reg.acq_time_sel);
  wire        st_chg   = (state_next != state_reg);
  wire        comp_s   = comp_ff_reg[1];
  wire [3:0]  bit_idx  = 4'(5'd10 - ph_cnt_reg);

  // one successive-approximation step
  function automatic logic [9:0] sar_step(input logic [9:0] code, input logic [3:0] b,
                                          input logic keep);
    logic [9:0] c;
    c    = code;
    c[b] = keep;
    if (b != 4'h0) begin
      c[b-4'h1] = 1'b1;
    end
    return c;
  endfunction : sar_step

  // completion, trigger and result formatting
  wire       on_now     = ctrl_reg.converter_on;
  wire       conv_done  = (state_reg == ST_CONV) && tad_tick && ctrl_reg.go && on_now &&
                          (ph_cnt_reg == CONV_TAD - 5'h1);
  wire [9:0] res_word   = sar_step(dac_reg, 4'h0, comp_s);
  wire [7:0] res_hi     = tim_reg.result_justify ? {6'h00, res_word[9:8]} : res_word[9:2];
  wire [7:0] res_lo     = tim_reg.result_justify ? res_word[7:0] : {res_word[1:0], 6'h00};
  wire       trig_mode  = compare_trig && (compare_mode_sel == TRIG_MODE);
  wire       trig_go    = trig_mode && on_now;
  wire       load_strap = (load_cnt_reg == 2'h2);

  // next control register: done clears go, trigger sets it
  wire       on_next  = wr_ctrl ? wdata_reg[0] : on_now;
  wire       go_wr    = wr_ctrl ? (wdata_reg[1] && wdata_reg[0]) : ctrl_reg.go;
  wire       go_next  = trig_go || (on_next && go_wr && !conv_done);
  wire [3:0] chs_next = wr_ctrl ? wdata_reg[5:2] : ctrl_reg.channel_sel;
  wire       done_nx  = conv_done || (done_reg && !(wr_stat && wdata_reg[0]));

  // sequencer next state; channel and pin direction never enter here
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF:    if (on_now) state_next = ST_DISCH;
      ST_DISCH:  if (tad_tick && ph_cnt_reg == WAIT_TAD - 5'h1) state_next = ST_SAMPLE;
      ST_SAMPLE: begin
        if (ctrl_reg.go) begin
          state_next = (tim_reg.acq_time_sel == ACQ_MANUAL) ? ST_DELAY : ST_ACQ;
        end
      end
      ST_ACQ: begin
        if (!ctrl_reg.go) state_next = ST_DISCH;
        else if (tad_tick && ph_cnt_reg == acq_len - 5'h1) state_next = ST_CONV;
      end
      ST_DELAY: begin
        if (!ctrl_reg.go) state_next = ST_DISCH;
        else if (ph_cnt_reg == INSTR_CYC - 5'h1) state_next = ST_CONV;
      end
      ST_CONV: begin
        if (!ctrl_reg.go || conv_done) state_next = ST_DISCH;
      end
      default:   state_next = ST_OFF;
    endcase
    if (!on_now) begin
      state_next = ST_OFF;
    end
  end

  // sequencer state and counters
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg   <= ST_OFF;
      tad_cnt_reg <= 8'h00;
      ph_cnt_reg  <= 5'h00;
    end else begin
      state_reg   <= state_next;
      tad_cnt_reg <= (st_chg || tad_tick) ? tad_len - 8'h1 : tad_cnt_reg - 8'h1;
      if (st_chg) ph_cnt_reg <= 5'h00;
      else if (state_reg == ST_DELAY || tad_tick) ph_cnt_reg <= ph_cnt_reg + 5'h1;
    end
  end

  // successive-approximation register, any selected pin converts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dac_reg <= 10'h000;
    end else if (state_next == ST_CONV && st_chg) begin
      dac_reg <= 10'h200;
    end else if (state_reg == ST_CONV && tad_tick && ph_cnt_reg != 5'h00) begin
      dac_reg <= sar_step(dac_reg, bit_idx, comp_s);
    end else if (state_reg != ST_CONV) begin
      dac_reg <= 10'h000;
    end
  end

  // control and config registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg     <= '0;
      tim_reg      <= '0;
      pcfg_reg     <= '0;
      done_reg     <= 1'b0;
      load_cnt_reg <= 2'h0;
    end else begin
      ctrl_reg     <= '{channel_sel: chs_next, go: go_next, converter_on: on_next};
      done_reg     <= done_nx;
      if (wr_tim) tim_reg <= adcs_timing_s'({wdata_reg[7], wdata_reg[5:0]});
      if (load_cnt_reg != 2'h3) load_cnt_reg <= load_cnt_reg + 2'h1;
      if (wr_pcfg) pcfg_reg <= wdata_reg[5:0];
      else if (load_strap) begin
        pcfg_reg.pin_analog_cfg <= strap_ff_reg[1] ? PCFG_ALL_ANALOG
                                                   : PCFG_PORTB_DIGITAL;
      end
    end
  end

  // result pair: completion wins, abort never writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      res_hi_reg <= RES_RST;
      res_lo_reg <= RES_RST;
    end else if (conv_done) begin
      res_hi_reg <= res_hi;
      res_lo_reg <= res_lo;
    end else begin
      if (wr_res_hi) res_hi_reg <= wdata_reg[7:0];
      if (wr_res_lo) res_lo_reg <= wdata_reg[7:0];
    end
  end

  // read mux, unimplemented bits zero
  wire [NUM_CH-1:0] port_rd = pin_ff2_reg & ~analog_mask(pcfg_reg.pin_analog_cfg);
  wire [31:0] rd_word =
    (araddr == OFF_RES_HI) ? {24'h0, res_hi_reg} :
    (araddr == OFF_RES_LO) ? {24'h0, res_lo_reg} :
    (araddr == OFF_CTRL)   ? {26'h0, ctrl_reg} :
    (araddr == OFF_PINCFG) ? {26'h0, pcfg_reg} :
    (araddr == OFF_TIMING) ? {24'h0, tim_reg.result_justify, 1'b0, tim_reg[5:0]} :
    (araddr == OFF_STATUS) ? {27'h0, state_reg, ctrl_reg.go, done_reg} :
    (araddr == OFF_PORT)   ? {19'h0, port_rd} : 32'h0;
  wire rd_hit = (araddr <= OFF_PORT) && (araddr[1:0] == 2'h0);

  // axi4-lite write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h0;
      wstrb0_reg  <= 1'b0;
    end else begin
      if (awvalid && awready_reg) begin
        awready_reg <= 1'b0;
        awaddr_reg  <= awaddr;
      end
      if (wvalid && wready_reg) begin
        wready_reg <= 1'b0;
        wdata_reg  <= wdata;
        wstrb0_reg <= wstrb[0];
      end
      if (do_write) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_reg && bready) begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  // axi4-lite read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0;
      rresp_reg   <= RESP_OKAY;
    end else if (arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= rd_hit ? rd_word : 32'h0;
      rresp_reg   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && rready) begin
      rvalid_reg  <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // analog control outputs from next state, timer clear from trigger mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample_reg      <= 1'b0;
      disch_reg       <= 1'b0;
      timer_clear_reg <= 1'b0;
    end else begin
      sample_reg      <= (state_next == ST_SAMPLE) || (state_next == ST_ACQ);
      disch_reg       <= (state_next == ST_DISCH);
      timer_clear_reg <= trig_mode;
    end
  end

  assign awready     = awready_reg;
  assign wready      = wready_reg;
  assign bvalid      = bvalid_reg;
  assign bresp       = bresp_reg;
  assign arready     = arready_reg;
  assign rvalid      = rvalid_reg;
  assign rdata       = rdata_reg;
  assign rresp       = rresp_reg;
  assign sample_en   = sample_reg;
  assign discharge   = disch_reg;
  assign channel_out = ctrl_reg.channel_sel;
  assign ref_sel     = {pcfg_reg.ref_high_sel, pcfg_reg.ref_low_sel};
  assign dac_code    = dac_reg;
  assign timer_clear = timer_clear_reg;

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  done_clears_go_a: assert property (conv_done && !trig_go |=> !ctrl_reg.go && done_reg)
    else $error("done did not clear go or set flag");
  result_written_a: assert property (conv_done |=>
                                     res_hi_reg == $past(res_hi) && res_lo_reg == $past(res_lo))
    else $error("result pair not written at completion");
  abort_keeps_a: assert property ((state_reg == ST_CONV) && !ctrl_reg.go &&
                                  !wr_res_hi && !wr_res_lo
                                  |=> $stable(res_hi_reg) && $stable(res_lo_reg))
    else $error("abort changed result pair");
  abort_stops_a: assert property ((state_reg == ST_CONV) && !ctrl_reg.go && on_now
                                  |=> state_reg == ST_DISCH)
    else $error("conversion not aborted");
  wait_len_a: assert property ((state_reg == ST_DISCH) && (state_next == ST_SAMPLE)
                               |-> tad_tick && ph_cnt_reg == WAIT_TAD - 5'h1)
    else $error("post-conversion wait wrong length");
  sample_after_disch_a: assert property ($rose(state_reg == ST_SAMPLE)
                                         |-> $past(state_reg) == ST_DISCH && $past(disch_reg))
    else $error("sampling without discharge");
  conv_len_a: assert property ($rose(state_reg == ST_CONV) ##1
                               (state_reg == ST_CONV)[*2] |-> ph_cnt_reg <= CONV_TAD - 5'h1)
    else $error("conversion phase count overrun");
  manual_start_a: assert property ((state_reg == ST_SAMPLE) && ctrl_reg.go && on_now &&
                                   tim_reg.acq_time_sel == ACQ_MANUAL
                                   |=> state_reg == ST_DELAY)
    else $error("manual start did not stop sampling");
  delay_len_a: assert property ((state_reg == ST_DELAY) && (state_next == ST_CONV)
                                |-> ph_cnt_reg == INSTR_CYC - 5'h1)
    else $error("instruction delay wrong length");
  delay_exit_a: assert property ($rose(state_reg == ST_DELAY) ##3
                                 (state_reg == ST_DELAY && ctrl_reg.go && on_now)
                                 |=> state_reg == ST_CONV)
    else $error("instruction delay not four cycles");
  acq_len_a: assert property ((state_reg == ST_ACQ) && (state_next == ST_CONV)
                              |-> tad_tick && ph_cnt_reg == acq_len - 5'h1)
    else $error("programmed acquisition wrong length");
  trig_sets_go_a: assert property (trig_go |=> ctrl_reg.go && timer_clear)
    else $error("trigger did not start conversion");
  trig_off_a: assert property (trig_mode && !on_now && !wr_ctrl
                               |=> !ctrl_reg.go && timer_clear)
    else $error("trigger while off mishandled");
  port_low_a: assert property (arvalid && arready_reg && araddr == OFF_PORT
                               |=> (rdata[NUM_CH-1:0] &
                                    analog_mask($past(pcfg_reg.pin_analog_cfg))) == '0)
    else $error("analog pin read high");
  rsvd_zero_a: assert property (arvalid && arready_reg && araddr == OFF_CTRL
                                |=> rdata[31:6] == 26'h0)
    else $error("reserved bits not zero");

  done_c:   cover property (conv_done);
  abort_c:  cover property ((state_reg == ST_CONV) && !ctrl_reg.go && on_now);
  trig_c:   cover property (trig_go ##[1:400] conv_done);
  manual_c: cover property ((state_reg == ST_DELAY) ##1 (state_reg == ST_CONV));
endmodule : adcs_sequencer

// >>> include/adcs_pkg.sv
// constants, types and helpers for the converter sequencer
package adcs_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_RES_HI = 8'h00;
  localparam logic [7:0] OFF_RES_LO = 8'h04;
  localparam logic [7:0] OFF_CTRL   = 8'h08;
  localparam logic [7:0] OFF_PINCFG = 8'h0c;
  localparam logic [7:0] OFF_TIMING = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_PORT   = 8'h18;
  // reset values
  localparam logic [3:0] PCFG_ALL_ANALOG    = 4'h0;
  localparam logic [3:0] PCFG_PORTB_DIGITAL = 4'h7;
  localparam logic [7:0] RES_RST            = 8'h00;
  // timing
  localparam int         CLK_NS     = 8;
  localparam int         RC_TAD_NS  = 1200;
  localparam logic [7:0] RC_DIV     = 8'((RC_TAD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0] INSTR_CYC  = 5'h04;
  localparam logic [4:0] WAIT_TAD   = 5'h02;
  localparam logic [4:0] CONV_TAD   = 5'h0b;
  localparam logic [2:0] ACQ_MANUAL = 3'h0;
  localparam logic [3:0] TRIG_MODE  = 4'hb;
  localparam int         NUM_CH     = 13;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // register layouts
  typedef struct packed {
    logic [3:0] channel_sel;
    logic       go;
    logic       converter_on;
  } adcs_ctrl_s;
  typedef struct packed {
    logic       ref_high_sel;
    logic       ref_low_sel;
    logic [3:0] pin_analog_cfg;
  } adcs_pincfg_s;
  typedef struct packed {
    logic       result_justify;
    logic [2:0] acq_time_sel;
    logic [2:0] conv_clock_sel;
  } adcs_timing_s;
  typedef enum logic [2:0] {
    ST_OFF    = 3'b000,
    ST_DISCH  = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_ACQ    = 3'b011,
    ST_DELAY  = 3'b100,
    ST_CONV   = 3'b101
  } adcs_state_e;
  // programmed acquisition length in bit periods
  function automatic logic [4:0] acq_tads(input logic [2:0] sel);
    case (sel)
      3'h1:    return 5'h02;
      3'h2:    return 5'h04;
      3'h3:    return 5'h06;
      3'h4:    return 5'h08;
      3'h5:    return 5'h0c;
      3'h6:    return 5'h10;
      3'h7:    return 5'h14;
      default: return 5'h00;
    endcase
  endfunction : acq_tads
  // clock cycles per bit period
  function automatic logic [7:0] tad_div(input logic [2:0] sel);
    case (sel)
      3'h0:    return 8'h02;
      3'h4:    return 8'h04;
      3'h1:    return 8'h08;
      3'h5:    return 8'h10;
      3'h2:    return 8'h20;
      3'h6:    return 8'h40;
      default: return RC_DIV;
    endcase
  endfunction : tad_div
  // pins that the pin config makes analog
  function automatic logic [NUM_CH-1:0] analog_mask(input logic [3:0] cfg);
    logic [4:0] n;
    logic [NUM_CH-1:0] m;
    n = (cfg <= 4'h2) ? 5'd13 : 5'(5'd15 - {1'b0, cfg});
    for (int i = 0; i < NUM_CH; i++) begin
      m[i] = (5'(i) < n);
    end
    return m;
  endfunction : analog_mask
endpackage : adcs_pkg

// >>> tb/adcs_front_model.sv
// behavioural analog front end: channel levels and comparator
module adcs_front_model
  import adcs_pkg::*;
(
  // clock
  input  wire logic       aclk,
  // converter side
  input  wire logic       sample_en,
  input  wire logic [3:0] channel_out,
  input  wire logic [9:0] dac_code,
  // comparator result
  output logic            comp_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] held = 10'h000;
  // pins are inputs here, so channel 3 shows level 0x2a5 and every other channel shows 0x0f0
  wire  [9:0] level = (channel_out == 4'h3) ? 10'h2a5 : 10'h0f0;
  // holding cap follows the pin while sampling, keeps its charge otherwise
  always_ff @(posedge aclk) begin
    if (sample_en) begin
      held <= level;
    end
  end
  // comparator: high while the held level is at or above the trial code
  assign comp_in = (held >= dac_code);
endmodule : adcs_front_model

// >>> tb/testbench.sv
// self-checking bench for the converter sequencer
module testbench;
  import adcs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, comp_in, trig, strap;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rd_val;
  logic [3:0]  wstrb, mode;
  logic [12:0] pins;
  wire         awready, wready, bvalid, arready, rvalid, sample_en, discharge, timer_clear;
  wire  [1:0]  bresp, rresp, ref_sel;
  wire  [31:0] rdata;
  wire  [3:0]  channel_out;
  wire  [9:0]  dac_code;
  int          miscompares = 0;
  int          comparisons = 0;

  adcs_sequencer DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .comp_in(comp_in), .sample_en(sample_en), .discharge(discharge),
    .channel_out(channel_out), .ref_sel(ref_sel), .dac_code(dac_code), .pin_in(pins),
    .portb_analog_reset_cfg(strap), .compare_mode_sel(mode), .compare_trig(trig),
    .timer_clear(timer_clear));
  adcs_front_model front (.aclk(aclk), .sample_en(sample_en), .channel_out(channel_out),
    .dac_code(dac_code), .comp_in(comp_in));

  // free-running 125 MHz clock
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic end_sim();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic hang();
    miscompares++;
    $display("FAIL at %0t: seen %h expected %h", $time, 32'h0, 32'h1);
    end_sim();
  endtask : hang

  // one axi4-lite write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 50) hang();
    chk(32'(bresp), 32'(er));
  endtask : wr

  // one axi4-lite read
  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    int n;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    d = rdata;
    if (n == 50) hang();
    chk(32'(rresp), 32'(er));
  endtask : rd

  // poll status until the done flag shows
  task automatic wait_done();
    int n;
    for (n = 0; n < 200; n++) begin
      rd(OFF_STATUS, RESP_OKAY, rd_val);
      if (rd_val[0] === 1'b1) break;
    end
    if (n == 200) hang();
  endtask : wait_done

  task automatic t_reset();
    rd(OFF_TIMING, RESP_OKAY, rd_val); chk(rd_val, 32'h0);
    rd(OFF_PINCFG, RESP_OKAY, rd_val); chk(rd_val, 32'h0);
    rd(8'h1c, RESP_SLVERR, rd_val); chk(rd_val, 32'h0);
    wr(8'h1c, 32'hff, RESP_SLVERR);
    wr(OFF_TIMING, 32'hff, RESP_OKAY);
    rd(OFF_TIMING, RESP_OKAY, rd_val); chk(rd_val, 32'hbf);
    rd(OFF_CTRL, RESP_OKAY, rd_val); chk(rd_val, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_port();
    pins <= 13'h1fff;
    wr(OFF_PINCFG, 32'h3c, RESP_OKAY);
    chk(32'(ref_sel), 32'h3);
    rd(OFF_PORT, RESP_OKAY, rd_val); chk(rd_val, 32'h1ff8);
    wr(OFF_PINCFG, 32'h00, RESP_OKAY);
    rd(OFF_PORT, RESP_OKAY, rd_val); chk(rd_val, 32'h0);
    $display("test port done");
  endtask : t_port

  // full conversion on a pin left digital, then left-justified repeat
  task automatic t_convert();
    wr(OFF_PINCFG, 32'h0f, RESP_OKAY);
    wr(OFF_TIMING, 32'h91, RESP_OKAY);
    wr(OFF_CTRL, 32'h0d, RESP_OKAY);
    chk(32'(channel_out), 32'h3);
    repeat (40) @(posedge aclk);
    chk(32'({sample_en, discharge}), 32'h2);
    wr(OFF_CTRL, 32'h0f, RESP_OKAY);
    wait_done();
    chk(32'(dac_code), 32'h0);
    rd(OFF_RES_HI, RESP_OKAY, rd_val); chk(rd_val, 32'h02);
    rd(OFF_RES_LO, RESP_OKAY, rd_val); chk(rd_val, 32'ha5);
    rd(OFF_STATUS, RESP_OKAY, rd_val); chk(32'(rd_val[1]), 32'h0);
    wr(OFF_STATUS, 32'h01, RESP_OKAY);
    wr(OFF_TIMING, 32'h11, RESP_OKAY);
    wr(OFF_CTRL, 32'h0f, RESP_OKAY);
    wait_done();
    rd(OFF_RES_HI, RESP_OKAY, rd_val); chk(rd_val, 32'ha9);
    rd(OFF_RES_LO, RESP_OKAY, rd_val); chk(rd_val, 32'h40);
    wr(OFF_STATUS, 32'h01, RESP_OKAY);
    // manual start, no programmed acquisition, slower bit clock
    wr(OFF_TIMING, 32'h85, RESP_OKAY);
    wr(OFF_CTRL, 32'h0f, RESP_OKAY);
    wait_done();
    rd(OFF_RES_HI, RESP_OKAY, rd_val); chk(rd_val, 32'h02);
    rd(OFF_RES_LO, RESP_OKAY, rd_val); chk(rd_val, 32'ha5);
    wr(OFF_STATUS, 32'h01, RESP_OKAY);
    $display("test convert done");
  endtask : t_convert

  // go cleared mid-run leaves the software-written result alone
  task automatic t_abort();
    wr(OFF_TIMING, 32'h91, RESP_OKAY);
    wr(OFF_RES_HI, 32'h5a, RESP_OKAY);
    repeat (40) @(posedge aclk);
    wr(OFF_CTRL, 32'h0f, RESP_OKAY);
    repeat (50) @(posedge aclk);
    wr(OFF_CTRL, 32'h0d, RESP_OKAY);
    repeat (200) @(posedge aclk);
    rd(OFF_RES_HI, RESP_OKAY, rd_val); chk(rd_val, 32'h5a);
    rd(OFF_STATUS, RESP_OKAY, rd_val); chk(32'(rd_val[1:0]), 32'h0);
    $display("test abort done");
  endtask : t_abort

  // channel and timing already chosen before each trigger
  task automatic pulse_trig();
    @(posedge aclk);
    trig <= 1'b1;
    @(posedge aclk);
    trig <= 1'b0;
    @(posedge aclk);
    chk(32'(timer_clear), 32'h1);
  endtask : pulse_trig

  task automatic t_trigger();
    mode <= TRIG_MODE;
    wr(OFF_CTRL, 32'h0c, RESP_OKAY);
    pulse_trig();
    rd(OFF_STATUS, RESP_OKAY, rd_val); chk(32'(rd_val[1]), 32'h0);
    wr(OFF_RES_HI, 32'h00, RESP_OKAY);
    wr(OFF_CTRL, 32'h0d, RESP_OKAY);
    repeat (40) @(posedge aclk);
    pulse_trig();
    wait_done();
    rd(OFF_RES_HI, RESP_OKAY, rd_val); chk(rd_val, 32'h02);
    $display("test trigger done");
  endtask : t_trigger

  // mid-run reset with the strap low: port b pins come up digital
  task automatic t_strap();
    strap   <= 1'b0;
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(OFF_PINCFG, RESP_OKAY, rd_val); chk(rd_val, 32'h07);
    rd(OFF_CTRL, RESP_OKAY, rd_val); chk(rd_val, 32'h0);
    $display("test strap done");
  endtask : t_strap

  // main sequence
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, trig} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = '0;
    mode = 4'h0;
    pins = '0;
    strap = 1'b1;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    t_reset();
    t_port();
    t_convert();
    t_abort();
    t_trigger();
    t_strap();
    end_sim();
  end
endmodule : testbench
